// >>> imudg_pkg.sv
// imudg_pkg.sv: shared constants and types of the diagnostic status bank
// assumes core_clk at 25 MHz and a 16-bit word serial link
package imudg_pkg;

  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned RECOVER_MS = 250;
  localparam int unsigned RECOVER_CYC = RECOVER_MS * (CLK_HZ / MS_PER_S);
  localparam int RCV_W = $clog2(RECOVER_CYC + 1);

  localparam int WORD_BITS = 16;
  localparam int HALF = 16;
  localparam int CNT_W = $clog2(WORD_BITS);
  localparam int ADDR_W = 7;

  // byte addresses; a word answers at its even and odd address
  localparam logic [ADDR_W-1:0] ADDR_DIAG = 7'h02;
  localparam logic [ADDR_W-1:0] ADDR_X_LO = 7'h04;
  localparam logic [ADDR_W-1:0] ADDR_X_HI = 7'h06;
  localparam logic [ADDR_W-1:0] ADDR_Y_LO = 7'h08;
  localparam logic [ADDR_W-1:0] ADDR_Y_HI = 7'h0a;
  localparam logic [ADDR_W-1:0] ADDR_Z_LO = 7'h0c;
  localparam logic [ADDR_W-1:0] ADDR_Z_HI = 7'h0e;
  localparam logic [ADDR_W-1:0] ADDR_MSC = 7'h60;

  localparam logic [WORD_BITS-1:0] DIAG_RST = 16'h0000;
  localparam logic [WORD_BITS-1:0] DIAG_USED = 16'h00fe;
  localparam logic [WORD_BITS-1:0] MSC_RST = 16'h00c1;

  localparam int BIT_CLK_ERR = 7;
  localparam int BIT_FLASH_TEST = 6;
  localparam int BIT_SENSOR = 5;
  localparam int BIT_STANDBY = 4;
  localparam int BIT_SPI_ERR = 3;
  localparam int BIT_FLASH_UPD = 2;
  localparam int BIT_OVERRUN = 1;

  localparam int SYNC_LSB = 2;
  localparam int SYNC_MSB = 4;
  localparam logic [2:0] SYNC_SCALED = 3'h2;

  // sync stage order: sclk, cs_n, mosi
  localparam logic [2:0] PIN_IDLE = 3'h6;
  localparam logic [1:0] PREV_IDLE = 2'h3;

  typedef struct packed {
    logic [2*HALF-1:0] x;
    logic [2*HALF-1:0] y;
    logic [2*HALF-1:0] z;
  } imudg_rate_t;

  typedef struct packed {
    logic clk_unlock;
    logic flash_crc_fail;
    logic selftest_fail;
    logic flash_update_fail;
    logic overrun;
  } imudg_event_t;

  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } imudg_cmd_t;

  typedef enum logic [1:0] {PWR_RUN, PWR_LOW, PWR_WAIT} imudg_pwr_t;

endpackage : imudg_pkg

// >>> imudg_spi_link.sv
// imudg_spi_link.sv: serial word engine, sampled on core_clk
// assumes mode 3 framing (sclk idles high) and sclk below core_clk / 4
`timescale 1ns/1ns
`default_nettype none
module imudg_spi_link
  import imudg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic [WORD_BITS-1:0] tx_word,
  output logic miso,
  output imudg_cmd_t rx_word,
  output logic word_valid,
  output logic frame_active,
  output logic frame_end,
  output logic frame_bad
);

  logic [2:0] s1_q, s2_q;
  logic [1:0] prev_q;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [WORD_BITS-1:0] rx_q, rx_d, sh_q, sh_d;
  logic miso_q, miso_d, wv_q, wv_d, act_q, act_d;
  logic fe_q, fe_d, fb_q, fb_d;
  logic sck_rise, sck_fall, cs_on, cs_fall, cs_rise;

  always_comb
  begin
    sck_rise = s2_q[2] & ~prev_q[1];
    sck_fall = ~s2_q[2] & prev_q[1];
    cs_on = ~s2_q[1];
    cs_fall = ~s2_q[1] & prev_q[0];
    cs_rise = s2_q[1] & ~prev_q[0];
    cnt_d = cnt_q;
    rx_d = rx_q;
    sh_d = sh_q;
    miso_d = miso_q;
    wv_d = 1'b0;
    fe_d = 1'b0;
    fb_d = fb_q;
    act_d = cs_on;
    if (cs_fall)
    begin
      cnt_d = '0;
    end
    else if (cs_on && sck_rise)
    begin
      rx_d = {rx_q[WORD_BITS-2:0], s2_q[0]};
      cnt_d = cnt_q + 1'b1;
      wv_d = (cnt_q == CNT_W'(WORD_BITS - 1));
    end
    // a new answer word is taken at the first falling edge of each word
    if (cs_on && sck_fall)
    begin
      if (cnt_q == '0)
      begin
        miso_d = tx_word[WORD_BITS-1];
        sh_d = {tx_word[WORD_BITS-2:0], 1'b0};
      end
      else
      begin
        miso_d = sh_q[WORD_BITS-1];
        sh_d = {sh_q[WORD_BITS-2:0], 1'b0};
      end
    end
    // the edge count runs over the whole select period, not per word
    if (cs_rise)
    begin
      fe_d = 1'b1;
      fb_d = (cnt_q != '0);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= PIN_IDLE;
      s2_q <= PIN_IDLE;
      prev_q <= PREV_IDLE;
      cnt_q <= '0;
      rx_q <= '0;
      sh_q <= '0;
      miso_q <= 1'b0;
      wv_q <= 1'b0;
      act_q <= 1'b0;
      fe_q <= 1'b0;
      fb_q <= 1'b0;
    end
    else
    begin
      s1_q <= {sclk, cs_n, mosi};
      s2_q <= s1_q;
      prev_q <= s2_q[2:1];
      cnt_q <= cnt_d;
      rx_q <= rx_d;
      sh_q <= sh_d;
      miso_q <= miso_d;
      wv_q <= wv_d;
      act_q <= act_d;
      fe_q <= fe_d;
      fb_q <= fb_d;
    end
  end

  assign miso = miso_q;
  assign rx_word = imudg_cmd_t'(rx_q);
  assign word_valid = wv_q;
  assign frame_active = act_q;
  assign frame_end = fe_q;
  assign frame_bad = fb_q;

endmodule : imudg_spi_link
`default_nettype wire

// >>> imudg_diag_status.sv
// imudg_diag_status.sv: diagnostic status flags and gyro rate words
// assumes event inputs and rate samples come from core_clk logic
`timescale 1ns/1ns
`default_nettype none
module imudg_diag_status
  import imudg_pkg::*;
#(
  parameter int unsigned RECOVER_CYCLES = RECOVER_CYC
)
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output wire logic spi_miso,
  input wire imudg_event_t events,
  input wire logic supply_low,
  input wire imudg_rate_t rate_in,
  input wire logic rate_valid,
  output logic data_halt
);

  logic [1:0] rst_s_q;
  logic rst_n;
  logic [1:0] sup_s_q;
  logic supply_low_s;

  imudg_cmd_t cmd;
  logic word_valid, frame_active, frame_end, frame_bad;

  imudg_pwr_t pwr_q, pwr_d;
  logic [RCV_W-1:0] pwr_cnt_q, pwr_cnt_d;
  logic standby_q, standby_d;

  logic [WORD_BITS-1:0] flags_q, flags_d, set_v;
  logic [WORD_BITS-1:0] msc_q, msc_d, tx_q, tx_d, rd_word;
  imudg_rate_t rate_q, rate_d, pend_q, pend_d;
  logic pend_v_q, pend_v_d;
  logic rd, wr, clr, scaled;

  // reset enters asynchronously, released through two stages
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_s_q <= '0;
    end
    else
    begin
      rst_s_q <= {rst_s_q[0], 1'b1};
    end
  end
  assign rst_n = rst_s_q[1];

  // supply comparator is asynchronous to core_clk
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sup_s_q <= '0;
    end
    else
    begin
      sup_s_q <= {sup_s_q[0], supply_low};
    end
  end
  assign supply_low_s = sup_s_q[1];

  imudg_spi_link u_link (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sclk(spi_sclk),
    .cs_n(spi_cs_n),
    .mosi(spi_mosi),
    .tx_word(tx_q),
    .miso(spi_miso),
    .rx_word(cmd),
    .word_valid(word_valid),
    .frame_active(frame_active),
    .frame_end(frame_end),
    .frame_bad(frame_bad)
  );

  // supply watch: processing restarts only after a full quiet period
  always_comb
  begin
    pwr_d = pwr_q;
    pwr_cnt_d = pwr_cnt_q;
    case (pwr_q)
      PWR_RUN:
      begin
        if (supply_low_s)
        begin
          pwr_d = PWR_LOW;
        end
      end
      PWR_LOW:
      begin
        if (!supply_low_s)
        begin
          pwr_d = PWR_WAIT;
          pwr_cnt_d = '0;
        end
      end
      PWR_WAIT:
      begin
        if (supply_low_s)
        begin
          pwr_d = PWR_LOW;
        end
        else if (pwr_cnt_q == RCV_W'(RECOVER_CYCLES - 1))
        begin
          pwr_d = PWR_RUN;
        end
        else
        begin
          pwr_cnt_d = pwr_cnt_q + 1'b1;
        end
      end
      default:
      begin
        pwr_d = PWR_RUN;
      end
    endcase
    standby_d = (pwr_d != PWR_RUN);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwr_q <= PWR_RUN;
      pwr_cnt_q <= '0;
      standby_q <= 1'b0;
    end
    else
    begin
      pwr_q <= pwr_d;
      pwr_cnt_q <= pwr_cnt_d;
      standby_q <= standby_d;
    end
  end
  assign data_halt = standby_q;

  // register bank: flags, control word, answer word, rate snapshots
  always_comb
  begin
    rd = word_valid && !cmd.wr;
    wr = word_valid && cmd.wr;
    clr = rd && (cmd.addr[ADDR_W-1:1] == ADDR_DIAG[ADDR_W-1:1]);
    scaled = (msc_q[SYNC_MSB:SYNC_LSB] == SYNC_SCALED);
    set_v = '0;
    set_v[BIT_CLK_ERR] = events.clk_unlock && scaled;
    set_v[BIT_FLASH_TEST] = events.flash_crc_fail;
    set_v[BIT_SENSOR] = events.selftest_fail;
    set_v[BIT_STANDBY] = supply_low_s;
    set_v[BIT_SPI_ERR] = frame_end && frame_bad;
    set_v[BIT_FLASH_UPD] = events.flash_update_fail;
    set_v[BIT_OVERRUN] = events.overrun;
    // set wins over the clearing read so no event is lost
    flags_d = ((clr ? DIAG_RST : flags_q) | set_v) & DIAG_USED;
    case (cmd.addr[ADDR_W-1:1])
      ADDR_DIAG[ADDR_W-1:1]: rd_word = flags_q;
      ADDR_X_LO[ADDR_W-1:1]: rd_word = rate_q.x[HALF-1:0];
      ADDR_X_HI[ADDR_W-1:1]: rd_word = rate_q.x[2*HALF-1:HALF];
      ADDR_Y_LO[ADDR_W-1:1]: rd_word = rate_q.y[HALF-1:0];
      ADDR_Y_HI[ADDR_W-1:1]: rd_word = rate_q.y[2*HALF-1:HALF];
      ADDR_Z_LO[ADDR_W-1:1]: rd_word = rate_q.z[HALF-1:0];
      ADDR_Z_HI[ADDR_W-1:1]: rd_word = rate_q.z[2*HALF-1:HALF];
      ADDR_MSC[ADDR_W-1:1]: rd_word = msc_q;
      default: rd_word = '0;
    endcase
    tx_d = tx_q;
    if (word_valid)
    begin
      tx_d = rd ? rd_word : '0;
    end
    // only the control word takes writes; the status word ignores them
    msc_d = msc_q;
    if (wr && cmd.addr == ADDR_MSC)
    begin
      msc_d[7:0] = cmd.data;
    end
    if (wr && cmd.addr == (ADDR_MSC | 7'h01))
    begin
      msc_d[15:8] = cmd.data;
    end
    // samples are held back while the host has the link selected
    rate_d = rate_q;
    pend_d = pend_q;
    pend_v_d = pend_v_q;
    if (!frame_active && pend_v_q)
    begin
      rate_d = pend_q;
      pend_v_d = 1'b0;
    end
    if (rate_valid && !standby_q)
    begin
      if (frame_active)
      begin
        pend_d = rate_in;
        pend_v_d = 1'b1;
      end
      else
      begin
        rate_d = rate_in;
        pend_v_d = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_q <= DIAG_RST;
      msc_q <= MSC_RST;
      tx_q <= '0;
      rate_q <= '0;
      pend_q <= '0;
      pend_v_q <= 1'b0;
    end
    else
    begin
      flags_q <= flags_d;
      msc_q <= msc_d;
      tx_q <= tx_d;
      rate_q <= rate_d;
      pend_q <= pend_d;
      pend_v_q <= pend_v_d;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_diag_read;
    rd && (cmd.addr[ADDR_W-1:1] == ADDR_DIAG[ADDR_W-1:1]);
  endsequence

  sequence s_x_lo_read;
    rd && (cmd.addr[ADDR_W-1:1] == ADDR_X_LO[ADDR_W-1:1]);
  endsequence

  sequence s_x_hi_read;
    rd && (cmd.addr[ADDR_W-1:1] == ADDR_X_HI[ADDR_W-1:1]);
  endsequence

  a_diag_answer: assert property (s_diag_read |=> tx_q == $past(flags_q))
    else $error("status answer differs from flags");
  a_clk_err_set: assert property (
    events.clk_unlock && scaled |=> flags_q[BIT_CLK_ERR])
    else $error("clock error flag not set");
  a_clk_err_gate: assert property (
    $rose(flags_q[BIT_CLK_ERR]) |-> $past(events.clk_unlock && scaled))
    else $error("clock error flag set outside scaled sync");
  a_flash_test: assert property (
    events.flash_crc_fail |=> flags_q[BIT_FLASH_TEST])
    else $error("flash test flag not set");
  a_self_test: assert property (
    events.selftest_fail |=> flags_q[BIT_SENSOR])
    else $error("sensor flag not set");
  a_supply_halt: assert property (
    supply_low_s |=> data_halt && flags_q[BIT_STANDBY])
    else $error("low supply did not halt and flag");
  a_recover_time: assert property (
    $fell(data_halt) |-> $past(pwr_cnt_q) == RCV_W'(RECOVER_CYCLES - 1))
    else $error("processing resumed before the quiet period");
  a_frame_error: assert property (
    frame_end && frame_bad |=> flags_q[BIT_SPI_ERR])
    else $error("framing error flag not set");
  a_update_fail: assert property (
    events.flash_update_fail |=> flags_q[BIT_FLASH_UPD])
    else $error("flash update flag not set");
  a_overrun_flag: assert property (events.overrun |=> flags_q[BIT_OVERRUN])
    else $error("overrun flag not set");
  a_rsvd_zero: assert property ((flags_q & ~DIAG_USED) == '0)
    else $error("reserved status bit set");
  a_read_clear: assert property (
    s_diag_read ##0 (set_v == '0) |=> flags_q == DIAG_RST)
    else $error("status read did not clear");
  a_flag_sticky: assert property (
    !clr |=> (flags_q & $past(flags_q)) == $past(flags_q))
    else $error("flag dropped without a read");
  a_flag_reset: assert property (
    clr && supply_low_s |=> flags_q[BIT_STANDBY])
    else $error("persisting condition lost after read");
  a_rate_high: assert property (
    s_x_hi_read |=> tx_q == $past(rate_q.x[2*HALF-1:HALF]))
    else $error("high rate word wrong");
  a_rate_low: assert property (
    s_x_lo_read |=> tx_q == $past(rate_q.x[HALF-1:0]))
    else $error("low rate word wrong");
  a_rate_hold: assert property (frame_active |=> rate_q == $past(rate_q))
    else $error("rate changed during a selected frame");

endmodule : imudg_diag_status
`default_nettype wire

// >>> imudg_spi_host.sv
// imudg_spi_host.sv: behavioural spi mode 3 host for the status bank
// assumes the bench loads tx_q before frame and reads rx_q afterwards
`timescale 1ns/1ns
`default_nettype none
module imudg_spi_host
  import imudg_pkg::*;
(
  output var logic sclk,
  output var logic cs_n,
  output var logic mosi,
  input wire logic miso
);
  logic [WORD_BITS-1:0] tx_q [0:6];
  logic [WORD_BITS-1:0] rx_q [0:6];

  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // a count that is not whole words is how a framing fault is provoked
  task automatic frame(input int nbits);
    int i;
    cs_n = 1'b0;
    #200;
    for (i = 0; i < nbits; i++)
    begin
      sclk = 1'b0;
      // miso moves some core cycles after a fall, so take it at the next
      if (i > 0)
        rx_q[(i-1)/16][15-(i-1)%16] = miso;
      mosi = tx_q[i/16][15-i%16];
      #160;
      sclk = 1'b1;
      #160;
    end
    rx_q[(nbits-1)/16][15-(nbits-1)%16] = miso;
    cs_n = 1'b1;
    // released line must not look like held data
    mosi = ~mosi;
    #400;
  endtask : frame
endmodule : imudg_spi_host
`default_nettype wire

// >>> imudg_diag_status_tb.sv
// imudg_diag_status_tb.sv: self-checking bench of the status bank
// assumes the host model drives the link; bench drives the rest
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) \
  begin \
    checks++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); \
    end \
  end
module imudg_diag_status_tb
  import imudg_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset_n;
  wire spi_sclk, spi_cs_n, spi_mosi, spi_miso;
  imudg_event_t events;
  logic supply_low;
  imudg_rate_t rate_in;
  logic rate_valid;
  logic data_halt;
  logic [WORD_BITS-1:0] d;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;

  always #20 core_clk = ~core_clk;

  // short recovery so the standby exit fits the run
  imudg_diag_status #(.RECOVER_CYCLES(20)) imudg_diag_status_inst (
    .core_clk(core_clk), .reset_n(reset_n), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .events(events), .supply_low(supply_low), .rate_in(rate_in),
    .rate_valid(rate_valid), .data_halt(data_halt));

  imudg_spi_host imudg_spi_host_inst (.sclk(spi_sclk), .cs_n(spi_cs_n),
    .mosi(spi_mosi), .miso(spi_miso));

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] v);
    imudg_spi_host_inst.tx_q[0] = {1'b0, a, 8'h00};
    imudg_spi_host_inst.tx_q[1] = 16'h0000;
    imudg_spi_host_inst.frame(32);
    v = imudg_spi_host_inst.rx_q[1];
  endtask : rd

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    imudg_spi_host_inst.tx_q[0] = {1'b1, a, v};
    imudg_spi_host_inst.frame(16);
  endtask : wr

  task automatic pulse_ev(input logic [4:0] v);
    @(negedge core_clk);
    events = v;
    @(negedge core_clk);
    events = '0;
    repeat (3) @(negedge core_clk);
  endtask : pulse_ev

  task automatic set_supply(input logic lvl, input int n);
    @(negedge core_clk);
    supply_low = lvl;
    repeat (n) @(negedge core_clk);
  endtask : set_supply

  task automatic set_reset(input logic lvl, input int n);
    @(negedge core_clk);
    reset_n = lvl;
    repeat (n) @(negedge core_clk);
  endtask : set_reset

  task automatic t_events;
    logic [15:0] ev_exp [0:3] = '{16'h0002, 16'h0004, 16'h0020, 16'h0040};
    int k;
    rd(ADDR_DIAG, d);
    `CHK(d, DIAG_RST)
    for (k = 0; k < 4; k++)
    begin
      pulse_ev(5'(1 << k));
      rd((k == 0) ? ADDR_DIAG + 7'h01 : ADDR_DIAG, d);
      `CHK(d, ev_exp[k])
    end
    pulse_ev(5'h0f);
    rd(ADDR_DIAG, d);
    `CHK(d, 16'h0066)
    rd(ADDR_DIAG, d);
    `CHK(d, 16'h0000)
    // a failed test is simply run again and must report afresh
    pulse_ev(5'h0c);
    rd(ADDR_DIAG, d);
    `CHK(d, 16'h0060)
  endtask : t_events

  task automatic t_sync;
    pulse_ev(5'h10);
    rd(ADDR_DIAG, d);
    `CHK(d, 16'h0000)
    wr(ADDR_MSC, 8'hc9);
    rd(ADDR_MSC, d);
    `CHK(d, 16'h00c9)
    wr(ADDR_MSC + 7'h01, 8'h12);
    rd(ADDR_MSC + 7'h01, d);
    `CHK(d, 16'h12c9)
    @(negedge core_clk);
    events = 5'h10;
    rd(ADDR_DIAG, d);
    `CHK(d, 16'h0080)
    rd(ADDR_DIAG, d);
    `CHK(d, 16'h0080)
    @(negedge core_clk);
    events = '0;
    rd(ADDR_DIAG, d);
    `CHK(d, 16'h0080)
    rd(ADDR_DIAG, d);
    `CHK(d, 16'h0000)
  endtask : t_sync

  task automatic t_frame;
    imudg_spi_host_inst.tx_q[0] = 16'h0000;
    imudg_spi_host_inst.frame(8);
    rd(ADDR_DIAG, d);
    `CHK(d, 16'h0008)
    // clean repeat of the sequence after a framing fault
    rd(ADDR_DIAG, d);
    `CHK(d, 16'h0000)
    wr(ADDR_DIAG, 8'hff);
    wr(ADDR_DIAG + 7'h01, 8'hff);
    rd(ADDR_DIAG, d);
    `CHK(d, 16'h0000)
  endtask : t_frame

  task automatic t_supply;
    set_supply(1'b1, 6);
    `CHK(data_halt, 1'b1)
    set_supply(1'b0, 9);
    `CHK(data_halt, 1'b1)
    repeat (20) @(negedge core_clk);
    `CHK(data_halt, 1'b0)
    rd(ADDR_DIAG, d);
    `CHK(d, 16'h0010)
  endtask : t_supply

  task automatic cmp_rates(input logic [31:0] v [0:2]);
    int k;
    for (k = 0; k < 3; k++)
    begin
      `CHK(imudg_spi_host_inst.rx_q[2*k+1], v[k][15:0])
      `CHK(imudg_spi_host_inst.rx_q[2*k+2], v[k][31:16])
    end
  endtask : cmp_rates

  task automatic t_rate;
    logic [31:0] a [0:2] = '{32'h4e200000, 32'hb1e00000, 32'h00000001};
    logic [31:0] b [0:2] = '{32'hffffffff, 32'h00000002, 32'hfffffffe};
    int k;
    @(negedge core_clk);
    rate_in = {a[0], a[1], a[2]};
    rate_valid = 1'b1;
    @(negedge core_clk);
    rate_valid = 1'b0;
    for (k = 0; k < 6; k++)
      imudg_spi_host_inst.tx_q[k] = {1'b0, 7'(ADDR_X_LO + 2*k), 8'h00};
    imudg_spi_host_inst.tx_q[6] = 16'h0000;
    // a new sample lands mid-frame and must not split a pair
    fork
      imudg_spi_host_inst.frame(112);
      begin
        repeat (40) @(negedge core_clk);
        rate_in = {b[0], b[1], b[2]};
        rate_valid = 1'b1;
        @(negedge core_clk);
        rate_valid = 1'b0;
      end
    join
    cmp_rates(a);
    imudg_spi_host_inst.frame(112);
    cmp_rates(b);
  endtask : t_rate

  // a mid-run reset must drop standby and return the status, control and x high rate words to default
  task automatic t_reset;
    set_supply(1'b1, 6);
    `CHK(data_halt, 1'b1)
    set_reset(1'b0, 2);
    `CHK(data_halt, 1'b0)
    set_supply(1'b0, 2);
    set_reset(1'b1, 8);
    `CHK(data_halt, 1'b0)
    rd(ADDR_DIAG, d);
    `CHK(d, DIAG_RST)
    rd(ADDR_MSC, d);
    `CHK(d, MSC_RST)
    rd(ADDR_X_HI, d);
    `CHK(d, 16'h0000)
  endtask : t_reset

  task end_sim;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 50000)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t run hung", $time);
      end_sim;
    end
  end

  initial
  begin
    reset_n = 1'b0;
    events = '0;
    supply_low = 1'b0;
    rate_in = '0;
    rate_valid = 1'b0;
    repeat (5) @(negedge core_clk);
    set_reset(1'b1, 8);
    t_events;
    t_sync;
    t_frame;
    t_supply;
    t_rate;
    t_reset;
    end_sim;
  end
endmodule : imudg_diag_status_tb
`default_nettype wire
